// ---- verif/udc_ctrl_tb.sv ----
// Purpose: Self-checking bench for the USB device control block
// Assumes: Short discharge and negotiation waits set by parameter
// Notes:   Read results are queued by the driver and checked on ack
`timescale 1ns/10ps

module udc_ctrl_tb
   import udc_pkg::*;
;
   localparam int          DISCH = 20;
   localparam int          HNP   = 50;
   // Arbitrary name word
   localparam logic [31:0] NAME2 = 32'h5A5A0002;

   logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0, dat_o, desc;
   logic [3:0]  sel = 4'h0, st, dly = 4'h3;
   logic en = 0, frz = 0, id = 1, vb = 0, oc = 0, vdr = 0, srp = 0, hnp = 0;
   logic susp = 0, acon = 0, bcon = 0, rcmd = 0, tcmd = 0;
   logic [6:0]  taddr = 7'h00, dba, ta;
   logic ack, nak, ls, pu, rsm, av, match, brst, rdone, tv;
   int error_cnt = 0, n_compared = 0, n;
   logic [31:0] expq[$], d;
   logic [6:0]  a;

   initial forever #4 clk_i = ~clk_i;

   udc_ctrl #(.DISCH_CYC(udc_cnt_t'(DISCH)), .HNP_CYC(udc_cnt_t'(HNP)),
              .NAME_WORD_2(NAME2)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .controller_enable_i(en), .clock_freeze_i(frz), .usb_bus_reset_i(brst),
      .resume_done_i(rdone), .id_pin_i(id), .vbus_valid_i(vb), .over_current_i(oc),
      .vbus_drive_req_i(vdr), .srp_req_i(srp), .hnp_req_i(hnp), .bus_suspend_i(susp),
      .a_connect_i(acon), .b_connect_i(bcon), .token_valid_i(tv), .token_addr_i(ta),
      .dual_role_state_o(st), .descriptor_base_o(desc), .nak_all_o(nak),
      .low_speed_force_o(ls), .pullup_enable_o(pu), .resume_request_o(rsm),
      .address_valid_o(av), .device_bus_address_o(dba), .addr_match_o(match));

   udc_host_model host_u (
      .clk_i(clk_i), .resume_req_i(rsm), .reset_cmd_i(rcmd), .tok_cmd_i(tcmd),
      .tok_addr_i(taddr), .dly_i(dly), .bus_reset_o(brst), .resume_done_o(rdone),
      .token_valid_o(tv), .token_addr_o(ta));

   task automatic give_verdict();
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic fail(input string m);
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
         fail($sformatf("read %h expected %h", g, e));
   endtask

   task automatic cmp_bit(input logic g, input logic e, input string m);
      n_compared++;
      if (g !== e)
         fail(m);
   endtask

   task automatic cmp_num(input int g, input int lo, input int hi);
      n_compared++;
      if (g < lo || g > hi)
         fail($sformatf("dwell %0d cycles", g));
   endtask

   // Classic single cycle, held until ack is sampled; only the watchdog ends a hang
   task automatic wb(input logic w, input logic [11:0] ad, input logic [31:0] dd,
                     input logic [3:0] s);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= ad;
      wdat <= dd;
      sel <= s;
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      cyc <= 0;
      stb <= 0;
   endtask

   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      expq.push_back(e);
      wb(1'b0, ad, 32'h0, 4'hF);
   endtask

   task automatic wr(input logic [11:0] ad, input logic [31:0] dd);
      wb(1'b1, ad, dd, 4'hF);
   endtask

   task automatic tok(input logic [6:0] ad, input logic e);
      @(posedge clk_i);
      tcmd <= 1;
      taddr <= ad;
      @(posedge clk_i);
      tcmd <= 0;
      @(negedge clk_i);
      cmp_bit(match, e, "address match");
   endtask

   task automatic wait_st(input logic [3:0] c);
      int k;
      k = 0;
      while (st !== c && k < 300)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 300)
         fail($sformatf("state %0d not reached", c));
   endtask

   task automatic dwell(input logic [3:0] c, output int m);
      m = 0;
      while (st === c && m < 1000)
      begin
         m++;
         @(posedge clk_i);
      end
   endtask

   // ---------------------------------------------------------------
   // Read checker
   // ---------------------------------------------------------------
   always @(posedge clk_i)
      if (ack === 1'b1 && we === 1'b0)
      begin
         if (expq.size() == 0)
            fail("unexpected read");
         else
            cmp_word(dat_o, expq.pop_front());
      end

   initial
   begin
      #400000;
      fail("timeout");
      give_verdict();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(48204));
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      rd(12'h000, 32'h100);
      @(negedge clk_i) cmp_bit(pu, 1'b0, "pullup");
      wr(12'h82C, 32'hF);
      rd(12'h82C, 32'h9);
      rd(12'h828, NAME2);
      rd(12'h004, 32'h0);
      d = $urandom;
      wr(12'h830, d);
      rd(12'h830, {d[31:3], 3'h0});
      @(negedge clk_i) cmp_word(desc, {d[31:3], 3'h0});
      @(posedge clk_i) en <= 1;
      wr(12'h000, 32'h20000);
      rd(12'h000, 32'h20000);
      @(negedge clk_i) cmp_bit(nak, 1'b1, "nak");
      cmp_bit(pu, 1'b1, "pullup");
      wr(12'h000, 32'h0);
      @(negedge clk_i) cmp_bit(nak, 1'b0, "nak");
      a = 7'($urandom_range(1, 127));
      tok(a, 1'b0);
      wr(12'h000, {24'h0, 1'b1, a});
      rd(12'h000, {24'h0, 1'b1, a});
      @(negedge clk_i) cmp_bit(av, 1'b1, "address valid");
      cmp_word({25'h0, dba}, {25'h0, a});
      tok(a, 1'b1);
      tok(7'h00, 1'b0);
      wr(12'h000, {25'h0, a});
      rd(12'h000, {24'h0, 1'b1, a});
      wb(1'b1, 12'h000, 32'h200, 4'h2);
      @(negedge clk_i) cmp_bit(rsm, 1'b1, "resume");
      n = 0;
      while (rdone !== 1'b1 && n < 50)
      begin
         @(posedge clk_i);
         n++;
      end
      @(negedge clk_i) cmp_bit(rsm, 1'b0, "resume");
      dly <= 4'hF;
      wb(1'b1, 12'h000, 32'h200, 4'h2);
      @(posedge clk_i) rcmd <= 1;
      @(posedge clk_i) rcmd <= 0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) cmp_bit(rsm, 1'b0, "resume");
      rd(12'h000, 32'h0);
      @(negedge clk_i) cmp_bit(av, 1'b0, "address valid");
      tok(a, 1'b0);
      tok(7'h00, 1'b1);
      wr(12'h000, 32'h1000);
      @(negedge clk_i) cmp_bit(ls, 1'b1, "speed");
      @(posedge clk_i) en <= 0;
      frz <= 1;
      wr(12'h000, 32'h20000);
      rd(12'h000, 32'h0);
      wr(12'h000, 32'h21100);
      rd(12'h000, 32'h1000);
      @(posedge clk_i) en <= 1;
      frz <= 0;
      rd(12'h000, 32'h1000);
      @(negedge clk_i) cmp_bit(ls, 1'b1, "speed");
      @(posedge clk_i) vb <= 1;
      wait_st(4'hA);
      susp <= 1;
      hnp <= 1;
      wait_st(4'hB);
      dwell(4'hB, n);
      cmp_num(n, HNP, HNP + 1);
      dwell(4'hC, n);
      cmp_num(n, DISCH, DISCH);
      cmp_bit(st === 4'hD, 1'b1, "state");
      @(posedge clk_i) acon <= 1;
      susp <= 0;
      wait_st(4'hE);
      @(posedge clk_i) rst_i <= 1;
      vb <= 0;
      susp <= 0;
      hnp <= 0;
      id <= 0;
      acon <= 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i) cmp_bit(st === 4'h9, 1'b1, "state");
      wait_st(4'h0);
      @(posedge clk_i) vdr <= 1;
      wait_st(4'h1);
      @(posedge clk_i) vb <= 1;
      wait_st(4'h2);
      @(posedge clk_i) oc <= 1;
      wait_st(4'h7);
      repeat (10) @(posedge clk_i);
      @(negedge clk_i) cmp_bit(st === 4'h7, 1'b1, "state");
      @(posedge clk_i) oc <= 0;
      wait_st(4'h8);
      dwell(4'h8, n);
      cmp_num(n, DISCH, DISCH);
      @(posedge clk_i) vb <= 0;
      vdr <= 0;
      wait_st(4'h0);
      @(posedge clk_i) vdr <= 1;
      vb <= 1;
      bcon <= 1;
      wait_st(4'h3);
      @(posedge clk_i) susp <= 1;
      wait_st(4'h4);
      @(posedge clk_i) hnp <= 1;
      bcon <= 0;
      susp <= 0;
      wait_st(4'h5);
      @(posedge clk_i) susp <= 1;
      id <= 1;
      wait_st(4'h6);
      @(posedge clk_i) vb <= 0;
      srp <= 1;
      wait_st(4'hF);
      @(posedge clk_i) vb <= 1;
      wait_st(4'hA);
      give_verdict();
   end
endmodule

// ---- verif/udc_host_model.sv ----
// Purpose: Far-side USB host model for the device control block
// Assumes: Bus reset and tokens are sent when the bench commands them
// Notes:   Resume end is reported dly_i plus one cycles after the request shows
`timescale 1ns/10ps

module udc_host_model
(
   input  wire logic       clk_i,
   input  wire logic       resume_req_i,
   input  wire logic       reset_cmd_i,
   input  wire logic       tok_cmd_i,
   input  wire logic [6:0] tok_addr_i,
   input  wire logic [3:0] dly_i,
   output logic            bus_reset_o,
   output logic            resume_done_o = 1'b0,
   output logic            token_valid_o = 1'b0,
   output logic      [6:0] token_addr_o = 7'h00
);
   int rcnt = 0;
   int wcnt = 0;

   // Bus reset lasts four cycles
   assign bus_reset_o = (rcnt != 0);

   always @(posedge clk_i)
   begin
      if (reset_cmd_i)
         rcnt <= 4;
      else if (rcnt != 0)
         rcnt <= rcnt - 1;
      wcnt <= (!resume_req_i || resume_done_o) ? 0 : wcnt + 1;
      resume_done_o <= resume_req_i && !resume_done_o && (wcnt == int'(dly_i));
      token_valid_o <= tok_cmd_i;
      // Idle address flips so a stale value never matches by luck
      token_addr_o <= tok_cmd_i ? tok_addr_i : ~token_addr_o;
   end
endmodule

// ---- verilog/udc_ctrl.sv ----
// Purpose: Dual-role state, descriptor base, name words and device control
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes:   Line status arrives as synchronous levels from the transceiver logic
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`include "udc_map.svh"

module udc_ctrl
   import udc_pkg::*;
#(
   parameter udc_cnt_t    DISCH_CYC   = udc_cnt_t'(`UDC_DISCH_CYC),
   parameter udc_cnt_t    HNP_CYC     = udc_cnt_t'(`UDC_HNP_WAIT_CYC),
   // Arbitrary neutral name words
   parameter logic [31:0] NAME_WORD_1 = 32'h4E414D45,
   parameter logic [31:0] NAME_WORD_2 = 32'h30303031
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        controller_enable_i,
   input  wire logic        clock_freeze_i,
   input  wire logic        usb_bus_reset_i,
   input  wire logic        resume_done_i,
   input  wire logic        id_pin_i,
   input  wire logic        vbus_valid_i,
   input  wire logic        over_current_i,
   input  wire logic        vbus_drive_req_i,
   input  wire logic        srp_req_i,
   input  wire logic        hnp_req_i,
   input  wire logic        bus_suspend_i,
   input  wire logic        a_connect_i,
   input  wire logic        b_connect_i,
   input  wire logic        token_valid_i,
   input  wire logic [6:0]  token_addr_i,
   output logic      [3:0]  dual_role_state_o,
   output logic      [31:0] descriptor_base_o,
   output logic             nak_all_o,
   output logic             low_speed_force_o,
   output logic             pullup_enable_o,
   output logic             resume_request_o,
   output logic             address_valid_o,
   output logic      [6:0]  device_bus_address_o,
   output logic             addr_match_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   udc_drd_e    fsm;
   udc_drd_e    next_fsm;
   udc_cnt_t    timer;
   logic        global_nak;
   logic        low_speed_force;
   logic        detach;
   logic        remote_wakeup_request;
   logic        address_valid;
   logic [6:0]  device_bus_address;
   logic [31:3] descriptor_base;
   logic [31:0] ctrl_rd;
   logic [31:0] ctrl_new;
   logic [31:0] desc_new;
   logic [31:0] rd_mux;
   logic        req;
   logic        wr_stb;
   logic        wr_ctrl;
   logic        regs_open;

   assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Write lands on the edge at which the master samples ack
   assign wr_stb    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign wr_ctrl   = wr_stb && (wb_adr_i == `UDC_CTRL_OFS);
   // Gated bits ignore writes while the controller is off or its clock frozen
   assign regs_open = controller_enable_i && !clock_freeze_i;

   always_comb
   begin
      ctrl_rd = 32'h00000000;
      ctrl_rd[`UDC_GLOBAL_NAK_BIT]   = global_nak;
      ctrl_rd[`UDC_LS_BIT]     = low_speed_force;
      ctrl_rd[`UDC_RMWK_BIT]   = remote_wakeup_request;
      ctrl_rd[`UDC_DETACH_BIT] = detach;
      ctrl_rd[`UDC_ADDRESS_VALID_BIT]  = address_valid;
      ctrl_rd[`UDC_ADDR_MSB:0] = device_bus_address;
   end

   assign ctrl_new = wb_merge(ctrl_rd, wb_dat_i, wb_sel_i);
   assign desc_new = wb_merge(descriptor_base_o, wb_dat_i, wb_sel_i);

   always_comb
   begin
      unique case (wb_adr_i)
         `UDC_CTRL_OFS:  rd_mux = ctrl_rd;
         `UDC_NAME1_OFS: rd_mux = NAME_WORD_1;
         `UDC_NAME2_OFS: rd_mux = NAME_WORD_2;
         `UDC_FSM_OFS:   rd_mux = {28'h0000000, fsm};
         `UDC_DESC_OFS:  rd_mux = descriptor_base_o;
         // Unmapped reads return zero and still acknowledge
         default:        rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // Descriptor base
   // ---------------------------------------------------------------
   // low bits never stored
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         descriptor_base <= 29'h00000000;
      else if (wr_stb && (wb_adr_i == `UDC_DESC_OFS))
         descriptor_base <= desc_new[31:3];
   end

   assign descriptor_base_o = {descriptor_base, `UDC_DESC_ZERO_W'(0)};

   // ---------------------------------------------------------------
   // Device control
   // ---------------------------------------------------------------
   // global NAK control
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         global_nak <= 1'b0;
      else if (wr_ctrl && regs_open)
         global_nak <= ctrl_new[`UDC_GLOBAL_NAK_BIT];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         low_speed_force <= 1'b0;
      else if (wr_ctrl)
         low_speed_force <= ctrl_new[`UDC_LS_BIT];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         detach <= 1'(`UDC_CTRL_RESET >> `UDC_DETACH_BIT);
      else if (wr_ctrl && regs_open)
         detach <= ctrl_new[`UDC_DETACH_BIT];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         remote_wakeup_request <= 1'b0;
      else if (usb_bus_reset_i || resume_done_i)
         remote_wakeup_request <= 1'b0;
      else if (wr_ctrl && regs_open && ctrl_new[`UDC_RMWK_BIT])
         remote_wakeup_request <= 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         address_valid <= 1'b0;
      else if (usb_bus_reset_i)
         address_valid <= 1'b0;
      else if (wr_ctrl && regs_open && ctrl_new[`UDC_ADDRESS_VALID_BIT])
         address_valid <= 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         device_bus_address <= 7'h00;
      else if (usb_bus_reset_i)
         device_bus_address <= 7'h00;
      else if (wr_ctrl && regs_open)
         device_bus_address <= ctrl_new[`UDC_ADDR_MSB:0];
   end

   assign nak_all_o            = global_nak;
   assign low_speed_force_o    = low_speed_force;
   assign pullup_enable_o      = !detach;
   assign resume_request_o     = remote_wakeup_request;
   assign address_valid_o      = address_valid;
   assign device_bus_address_o = device_bus_address;

   assign addr_match_o = token_valid_i &&
                         (token_addr_i == (address_valid ? device_bus_address : 7'h00));

   // ---------------------------------------------------------------
   // Dual-role state machine
   // ---------------------------------------------------------------
   // transitions per role
   always_comb
   begin
      next_fsm = fsm;
      unique case (fsm)
         A_IDLE:
            if (id_pin_i)
               next_fsm = B_IDLE;
            else if (vbus_drive_req_i)
               next_fsm = A_WAIT_VRISE;
         A_WAIT_VRISE:
            if (over_current_i)
               next_fsm = A_VBUS_ERR;
            else if (vbus_valid_i)
               next_fsm = A_WAIT_BCON;
         A_WAIT_BCON:
            if (over_current_i)
               next_fsm = A_VBUS_ERR;
            else if (id_pin_i)
               next_fsm = A_WAIT_VFALL;
            else if (b_connect_i)
               next_fsm = A_HOST;
         A_HOST:
            if (over_current_i)
               next_fsm = A_VBUS_ERR;
            else if (!b_connect_i)
               next_fsm = A_WAIT_BCON;
            else if (bus_suspend_i)
               next_fsm = A_SUSPEND;
         A_SUSPEND:
            if (over_current_i)
               next_fsm = A_VBUS_ERR;
            else if (hnp_req_i && !b_connect_i)
               next_fsm = A_PERIPHERAL;
            else if (!bus_suspend_i)
               next_fsm = A_HOST;
         A_PERIPHERAL:
            if (over_current_i)
               next_fsm = A_VBUS_ERR;
            else if (bus_suspend_i)
               next_fsm = A_WAIT_BCON;
         A_WAIT_VFALL:
            if (!vbus_valid_i)
               next_fsm = A_IDLE;
         A_VBUS_ERR:
            if (!over_current_i)
               next_fsm = A_WAIT_DISCHARGE;
         A_WAIT_DISCHARGE:
            if (timer == DISCH_CYC - 20'd1)
               next_fsm = A_WAIT_VFALL;
         B_IDLE:
            if (!id_pin_i)
               next_fsm = A_IDLE;
            else if (vbus_valid_i)
               next_fsm = B_PERIPHERAL;
            else if (srp_req_i)
               next_fsm = B_SRP_INIT;
         B_PERIPHERAL:
            if (!vbus_valid_i)
               next_fsm = B_IDLE;
            else if (bus_suspend_i)
               next_fsm = B_WAIT_BEGIN_HNP;
         // negotiate after the wait, if asked
         B_WAIT_BEGIN_HNP:
            if (!bus_suspend_i)
               next_fsm = B_PERIPHERAL;
            else if (hnp_req_i && (timer >= HNP_CYC - 20'd1))
               next_fsm = B_WAIT_DISCHARGE;
         B_WAIT_DISCHARGE:
            if (timer == DISCH_CYC - 20'd1)
               next_fsm = B_WAIT_ACON;
         B_WAIT_ACON:
            if (!vbus_valid_i)
               next_fsm = B_IDLE;
            else if (a_connect_i)
               next_fsm = B_HOST;
         B_HOST:
            if (!a_connect_i || bus_suspend_i)
               next_fsm = B_PERIPHERAL;
         B_SRP_INIT:
            if (vbus_valid_i)
               next_fsm = B_PERIPHERAL;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fsm <= B_IDLE;
      else
         fsm <= next_fsm;
   end

   // Saturates so a long suspend cannot wrap the HNP wait
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (next_fsm != fsm))
         timer <= '0;
      else if (timer != '1)
         timer <= timer + 20'd1;
   end

   assign dual_role_state_o = fsm;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_fsm_reset;
      @(posedge clk_i) rst_i |=> (dual_role_state_o == `UDC_FSM_RESET);
   endproperty
   a_fsm_reset: assert property (p_fsm_reset) else $error("state not idle B after reset");

   property p_a_disch;
      @(posedge clk_i) disable iff (rst_i)
      (fsm == A_WAIT_DISCHARGE && timer < DISCH_CYC - 20'd1) |=> (fsm == A_WAIT_DISCHARGE);
   endproperty
   a_a_disch: assert property (p_a_disch) else $error("A discharge left early");

   property p_vbus_err;
      @(posedge clk_i) disable iff (rst_i)
      (over_current_i && fsm inside {A_WAIT_VRISE, A_WAIT_BCON, A_HOST, A_SUSPEND,
                                     A_PERIPHERAL, A_VBUS_ERR})
      |=> (dual_role_state_o == 4'h7);
   endproperty
   a_vbus_err: assert property (p_vbus_err) else $error("over-current not handled");

   property p_hnp_wait;
      @(posedge clk_i) disable iff (rst_i)
      (fsm == B_WAIT_BEGIN_HNP && bus_suspend_i && timer < HNP_CYC - 20'd1)
      |=> (fsm == B_WAIT_BEGIN_HNP);
   endproperty
   a_hnp_wait: assert property (p_hnp_wait) else $error("HNP wait cut short");

   property p_b_disch;
      @(posedge clk_i) disable iff (rst_i)
      (fsm == B_WAIT_BEGIN_HNP ##1 fsm == B_WAIT_DISCHARGE) |-> $past(hnp_req_i) ##0
      (fsm == B_WAIT_DISCHARGE) [*2];
   endproperty
   a_b_disch: assert property (p_b_disch) else $error("B discharge wrong");

   property p_b_disch_len;
      @(posedge clk_i) disable iff (rst_i)
      (fsm == B_WAIT_DISCHARGE && timer < DISCH_CYC - 20'd1) |=> (fsm == B_WAIT_DISCHARGE);
   endproperty
   a_b_disch_len: assert property (p_b_disch_len) else $error("B discharge cut short");

   property p_desc_low;
      @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && !wb_we_i && wb_adr_i == `UDC_DESC_OFS) |-> (wb_dat_o[2:0] == 3'h0);
   endproperty
   a_desc_low: assert property (p_desc_low) else $error("descriptor low bits nonzero");

   property p_global_nak;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && regs_open && wb_sel_i[2]) |=> (nak_all_o == $past(wb_dat_i[17]));
   endproperty
   a_global_nak: assert property (p_global_nak) else $error("global NAK not applied");

   property p_ls_frozen;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && !regs_open && wb_sel_i[1]) |=> (low_speed_force_o == $past(wb_dat_i[12]));
   endproperty
   a_ls_frozen: assert property (p_ls_frozen) else $error("speed write lost");

   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && regs_open && wb_sel_i[1] && wb_dat_i[9] && !usb_bus_reset_i
       && !resume_done_i) |=> resume_request_o;
   endproperty
   a_wake: assert property (p_wake) else $error("remote wakeup not started");

   property p_bus_reset;
      @(posedge clk_i) disable iff (rst_i)
      usb_bus_reset_i |=> (!resume_request_o && !address_valid_o
                           && device_bus_address_o == 7'h00);
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset did not clear");

   property p_detach_reset;
      @(posedge clk_i) rst_i |=> !pullup_enable_o;
   endproperty
   a_detach_reset: assert property (p_detach_reset) else $error("pull-up on after reset");

   property p_default_addr;
      @(posedge clk_i) disable iff (rst_i)
      (addr_match_o && !address_valid_o) |-> (token_addr_i == 7'h00);
   endproperty
   a_default_addr: assert property (p_default_addr) else $error("matched non-default");

endmodule

// ---- verilog/udc_map.svh ----
// Purpose: Offsets, field positions, reset values and timing for the USB device control block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave, 125 MHz clock
// Notes:   Definitions only
`ifndef UDC_MAP_SVH
`define UDC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define UDC_CTRL_OFS      12'h000
`define UDC_NAME1_OFS     12'h824
`define UDC_NAME2_OFS     12'h828
`define UDC_FSM_OFS       12'h82C
`define UDC_DESC_OFS      12'h830

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define UDC_GLOBAL_NAK_BIT      17
`define UDC_LS_BIT        12
`define UDC_RMWK_BIT      9
`define UDC_DETACH_BIT    8
`define UDC_ADDRESS_VALID_BIT     7
`define UDC_ADDR_MSB      6
`define UDC_CTRL_RESET    32'h00000100
`define UDC_FSM_RESET     4'h9
`define UDC_DESC_ZERO_W   3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define UDC_CLK_MHZ       125
`define UDC_DISCH_US      100
`define UDC_HNP_WAIT_US   3000
`define UDC_DISCH_CYC     (`UDC_DISCH_US * `UDC_CLK_MHZ)
`define UDC_HNP_WAIT_CYC  (`UDC_HNP_WAIT_US * `UDC_CLK_MHZ)

`endif

// ---- verilog/udc_pkg.sv ----
// Purpose: Types for the USB device control block
// Assumes: Enum order gives the dual-role state codes
// Notes:   Timing and offsets live in udc_map.svh
package udc_pkg;

   typedef enum logic [3:0] {
      A_IDLE,
      A_WAIT_VRISE,
      A_WAIT_BCON,
      A_HOST,
      A_SUSPEND,
      A_PERIPHERAL,
      A_WAIT_VFALL,
      A_VBUS_ERR,
      A_WAIT_DISCHARGE,
      B_IDLE,
      B_PERIPHERAL,
      B_WAIT_BEGIN_HNP,
      B_WAIT_DISCHARGE,
      B_WAIT_ACON,
      B_HOST,
      B_SRP_INIT
   } udc_drd_e;

   typedef logic [19:0] udc_cnt_t;

endpackage
